// ===== verilog/sfr_status_bank.sv
// status, fault and module-information read registers of the supply
// assumes: host reads over rd_en/rd_addr, commands over cmd_wr/cmd_data,
// all inputs synchronous to clk_sys
//
// Functional notes
// - fifteen-fraction-bit values are the real value times 2^15, as integers.
// - ten-fraction-bit values are the real value times 2^10, as integers.
// - 32-bit values read as two words, upper half first, lower half next.
// - writing the energy clear command bit zeroes the energy counter.
// - status bit 0 reads 1 while the output is on.
// - status fault bit sets on a fault and stays until fault clear command.
// - status bit 2 shows enable through the analog port.
// - status bit 3 shows enable through register-protocol programming.
// - status bit 4 reads 1 while regulating current.
// - status bit 5 reads 1 while regulating voltage.
// - in power or process regulation both mode bits read 1.
// - each fault cause has its own bit; any mix may be set.
// - codes 0x1 module, 0x2 impedance, 0x4 unmet setpoint.
// - codes 0x8 controller hardware, 0x10 supervisory, 0x400 warning.
// - 0x40 loop current under 2 mA; 0x20, 0x80 analog setpoint faults.
// - 0x100 sense error, 0x200 register-protocol traffic timeout.
// - 0x800 silent module, 0x1000 duplicate id, 0x2000 over 32 modules.
// - 0x4000 duplicate serial, 0x20000 fewer modules than expected.
// - 0x8000 impedance slope too high, 0x10000 cable impedance too high.
// - 0x40000 phase loss, 0x80000 analog inhibit, 0x100000 analog overload.
// - module information word holds the bus address in bits 0 to 11.
// - the status word reads at address 0.
// - module information words read at addresses 100 to 131.
`timescale 1ns/1ps
`include "sfr_map.svh"

module sfr_status_bank (
   // clock, reset, enable
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic ce,
   // register read port
   input wire logic rd_en,
   input wire logic [15:0] rd_addr,
   output logic [15:0] rd_data,
   output logic rd_valid,
   // command register write
   input wire logic cmd_wr,
   input wire logic [15:0] cmd_data,
   // unit operating state
   input wire logic unit_on,
   input wire logic analog_enabled,
   input wire logic bus_enabled,
   input wire logic current_reg,
   input wire logic voltage_reg,
   input wire logic power_reg,
   // monitors
   input wire logic [31:0] vmon_q15,
   input wire logic [31:0] imon_q15,
   input wire logic [31:0] pmon_q10,
   input wire logic energy_tick,
   // fault causes, level or pulse
   input wire logic flt_module,
   input wire logic flt_out_z,
   input wire logic flt_command,
   input wire logic flt_ctrl_hw,
   input wire logic flt_supervisory,
   input wire logic flt_analog_p,
   input wire logic flt_loop_low,
   input wire logic flt_analog_v,
   input wire logic flt_sense,
   input wire logic flt_bus_timeout,
   input wire logic flt_super_warn,
   input wire logic flt_unit_silent,
   input wire logic flt_dup_id,
   input wire logic flt_overcount,
   input wire logic flt_dup_serial,
   input wire logic flt_z_slope,
   input wire logic flt_cable_z,
   input wire logic flt_undercount,
   input wire logic flt_phase,
   input wire logic flt_analog_inhibit,
   input wire logic flt_analog_overload,
   // module table load
   input wire logic minfo_wr,
   input wire logic [4:0] minfo_slot,
   input wire logic [11:0] minfo_bus_addr
);

   // ---------------------------------------------------------------
   // reset release
   // ---------------------------------------------------------------
   logic rst_meta_reg;
   logic rst_n_sync;

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         rst_meta_reg <= 1'b0;
         rst_n_sync <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_n_sync <= rst_meta_reg;
      end
   end

   // ---------------------------------------------------------------
   // command decode
   // ---------------------------------------------------------------
   wire fault_clr = cmd_wr && cmd_data[`SFR_CMD_FAULT_CLR];
   wire energy_clr = cmd_wr && cmd_data[`SFR_CMD_ENERGY_CLR];

   // ---------------------------------------------------------------
   // fault causes
   // ---------------------------------------------------------------
   sfr_fault_if fb ();
   sfr_pkg::sfr_fault_t cause;

   always_comb
   begin
      cause = `SFR_FAULT_RESET;
      cause[`SFR_F_MODULE] = flt_module;
      cause[`SFR_F_OUT_Z] = flt_out_z;
      cause[`SFR_F_COMMAND] = flt_command;
      cause[`SFR_F_CTRL_HW] = flt_ctrl_hw;
      cause[`SFR_F_SUPERVISORY] = flt_supervisory;
      cause[`SFR_F_SUPER_WARN] = flt_super_warn;
      cause[`SFR_F_ANALOG_P] = flt_analog_p;
      cause[`SFR_F_ANALOG_I] = flt_loop_low;
      cause[`SFR_F_ANALOG_V] = flt_analog_v;
      cause[`SFR_F_SENSE] = flt_sense;
      cause[`SFR_F_BUS_TIMEOUT] = flt_bus_timeout;
      cause[`SFR_F_UNIT_SILENT] = flt_unit_silent;
      cause[`SFR_F_DUP_ID] = flt_dup_id;
      cause[`SFR_F_OVERCOUNT] = flt_overcount;
      cause[`SFR_F_DUP_SERIAL] = flt_dup_serial;
      cause[`SFR_F_UNDERCOUNT] = flt_undercount;
      cause[`SFR_F_Z_SLOPE] = flt_z_slope;
      cause[`SFR_F_CABLE_Z] = flt_cable_z;
      cause[`SFR_F_PHASE] = flt_phase;
      cause[`SFR_F_ANALOG_INHIBIT] = flt_analog_inhibit;
      cause[`SFR_F_ANALOG_OVERLOAD] = flt_analog_overload;
   end

   assign fb.cause = cause;
   assign fb.clr = fault_clr;

   sfr_fault_trap u_trap (
      .clk_sys (clk_sys),
      .rst_n (rst_n_sync),
      .ce (ce),
      .fb (fb)
   );

   wire [31:0] fault_word = {11'h000, fb.flags};

   // ---------------------------------------------------------------
   // energy meter
   // ---------------------------------------------------------------
   logic [31:0] energy_count;

   sfr_energy_meter u_energy (
      .clk_sys (clk_sys),
      .rst_n (rst_n_sync),
      .ce (ce),
      .tick (energy_tick),
      .clr (energy_clr),
      .count (energy_count)
   );

   // ---------------------------------------------------------------
   // status word
   // ---------------------------------------------------------------
   logic [15:0] status_reg;
   logic [15:0] status_next;

   always_comb
   begin
      status_next = `SFR_ST_RESET;
      status_next[`SFR_ST_ON] = unit_on;
      status_next[`SFR_ST_ANALOG] = analog_enabled;
      status_next[`SFR_ST_BUS] = bus_enabled;
      status_next[`SFR_ST_CURRENT] = current_reg || power_reg;
      status_next[`SFR_ST_VOLTAGE] = voltage_reg || power_reg;
   end

   always_ff @(posedge clk_sys or negedge rst_n_sync)
   begin
      if (!rst_n_sync)
         status_reg <= `SFR_ST_RESET;
      else if (ce)
         status_reg <= status_next;
   end

   // fault bit comes straight from the trap so it tracks the cause bits
   wire [15:0] status_word = status_reg
      | ({15'h0000, fb.fault_flag} << `SFR_ST_FAULT);

   // ---------------------------------------------------------------
   // module information table
   // ---------------------------------------------------------------
   logic [11:0] minfo_mem [`SFR_MOD_COUNT];

   always_ff @(posedge clk_sys or negedge rst_n_sync)
   begin
      if (!rst_n_sync)
      begin
         for (int i = 0; i < `SFR_MOD_COUNT; i++)
            minfo_mem[i] <= 12'h000;
      end
      else if (ce && minfo_wr)
         minfo_mem[minfo_slot] <= minfo_bus_addr;
   end

   wire [15:0] minfo_off = rd_addr - `SFR_ADDR_MINFO_FIRST;
   wire addr_is_minfo = (rd_addr >= `SFR_ADDR_MINFO_FIRST)
      && (rd_addr <= `SFR_ADDR_MINFO_LAST);
   wire [15:0] minfo_word = {4'h0, minfo_mem[minfo_off[4:0]]};

   // ---------------------------------------------------------------
   // read selection
   // ---------------------------------------------------------------
   wire [31:0] pmon_q15 = sfr_pkg::sfr_q10_to_q15(pmon_q10);
   logic [15:0] rd_word;

   always_comb
   begin
      case (rd_addr)
         `SFR_ADDR_STATUS: rd_word = status_word;
         `SFR_ADDR_FAULT_HI: rd_word = sfr_pkg::sfr_hi_word(fault_word);
         `SFR_ADDR_FAULT_LO: rd_word = sfr_pkg::sfr_lo_word(fault_word);
         `SFR_ADDR_VMON_HI: rd_word = sfr_pkg::sfr_hi_word(vmon_q15);
         `SFR_ADDR_VMON_LO: rd_word = sfr_pkg::sfr_lo_word(vmon_q15);
         `SFR_ADDR_IMON_HI: rd_word = sfr_pkg::sfr_hi_word(imon_q15);
         `SFR_ADDR_IMON_LO: rd_word = sfr_pkg::sfr_lo_word(imon_q15);
         `SFR_ADDR_PMON_HI: rd_word = sfr_pkg::sfr_hi_word(pmon_q15);
         `SFR_ADDR_PMON_LO: rd_word = sfr_pkg::sfr_lo_word(pmon_q15);
         `SFR_ADDR_ENERGY_HI: rd_word = sfr_pkg::sfr_hi_word(energy_count);
         `SFR_ADDR_ENERGY_LO: rd_word = sfr_pkg::sfr_lo_word(energy_count);
         default: rd_word = addr_is_minfo ? minfo_word : 16'h0000;
      endcase
   end

   // ---------------------------------------------------------------
   // read answer
   // ---------------------------------------------------------------
   logic [15:0] rd_data_reg;
   logic rd_valid_reg;

   always_ff @(posedge clk_sys or negedge rst_n_sync)
   begin
      if (!rst_n_sync)
      begin
         rd_data_reg <= 16'h0000;
         rd_valid_reg <= 1'b0;
      end
      else if (ce)
      begin
         rd_valid_reg <= rd_en;
         if (rd_en)
            rd_data_reg <= rd_word;
      end
   end

   assign rd_data = rd_data_reg;
   assign rd_valid = rd_valid_reg;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sequence s_read(logic [15:0] a);
      ce && rd_en && rd_addr == a;
   endsequence

   sequence s_fault_then_read;
      ce && flt_loop_low ##1 s_read(`SFR_ADDR_FAULT_LO);
   endsequence

   property p_status_on;
      @(posedge clk_sys) disable iff (!rst_n_sync)
      ce && unit_on ##1 s_read(`SFR_ADDR_STATUS)
         |=> rd_valid && rd_data[`SFR_ST_ON];
   endproperty
   a_status_on: assert property (p_status_on)
      else $error("on bit not shown");

   property p_power_mode;
      @(posedge clk_sys) disable iff (!rst_n_sync)
      ce && power_reg ##1 s_read(`SFR_ADDR_STATUS)
         |=> rd_data[`SFR_ST_CURRENT] && rd_data[`SFR_ST_VOLTAGE];
   endproperty
   a_power_mode: assert property (p_power_mode)
      else $error("power mode does not show both mode bits");

   property p_mode_bits;
      @(posedge clk_sys) disable iff (!rst_n_sync)
      ce && !power_reg ##1 s_read(`SFR_ADDR_STATUS)
         |=> rd_data[`SFR_ST_CURRENT] == $past(current_reg, 2)
         && rd_data[`SFR_ST_VOLTAGE] == $past(voltage_reg, 2)
         && rd_data[`SFR_ST_ANALOG] == $past(analog_enabled, 2)
         && rd_data[`SFR_ST_BUS] == $past(bus_enabled, 2);
   endproperty
   a_mode_bits: assert property (p_mode_bits)
      else $error("status mode bits wrong");

   property p_status_unused;
      @(posedge clk_sys) disable iff (!rst_n_sync)
      s_read(`SFR_ADDR_STATUS) |=> rd_data[15:6] == 10'h000;
   endproperty
   a_status_unused: assert property (p_status_unused)
      else $error("unused status bits not zero");

   property p_loop_low_code;
      @(posedge clk_sys) disable iff (!rst_n_sync)
      s_fault_then_read |=> rd_data[6];
   endproperty
   a_loop_low_code: assert property (p_loop_low_code)
      else $error("loop current fault not at code 0x40");

   property p_fault_hi_word;
      @(posedge clk_sys) disable iff (!rst_n_sync)
      ce && flt_analog_overload ##1 s_read(`SFR_ADDR_FAULT_HI)
         |=> rd_data[4] && rd_data[15:5] == 11'h000;
   endproperty
   a_fault_hi_word: assert property (p_fault_hi_word)
      else $error("fault high word wrong");

   property p_minfo_read;
      @(posedge clk_sys) disable iff (!rst_n_sync)
      s_read(`SFR_ADDR_MINFO_FIRST) |=> rd_data == {4'h0, $past(minfo_mem[0])};
   endproperty
   a_minfo_read: assert property (p_minfo_read)
      else $error("module information word wrong");

   property p_status_fault;
      @(posedge clk_sys) disable iff (!rst_n_sync)
      s_read(`SFR_ADDR_STATUS)
         |=> rd_data[`SFR_ST_FAULT] == $past(fb.fault_flag);
   endproperty
   a_status_fault: assert property (p_status_fault)
      else $error("status fault bit differs from trap");

endmodule

// ===== include/sfr_map.svh
// register addresses, bit positions and reset values of the status bank
// assumes: included by the package and by every design file that decodes
`ifndef SFR_MAP_SVH
`define SFR_MAP_SVH

// ---------------------------------------------------------------
// read map, 16-bit register addresses
// ---------------------------------------------------------------
`define SFR_ADDR_STATUS 16'h0000
`define SFR_ADDR_FAULT_HI 16'h0001
`define SFR_ADDR_FAULT_LO 16'h0002
`define SFR_ADDR_VMON_HI 16'h0003
`define SFR_ADDR_VMON_LO 16'h0004
`define SFR_ADDR_IMON_HI 16'h0005
`define SFR_ADDR_IMON_LO 16'h0006
`define SFR_ADDR_PMON_HI 16'h0007
`define SFR_ADDR_PMON_LO 16'h0008
`define SFR_ADDR_ENERGY_HI 16'h001f
`define SFR_ADDR_ENERGY_LO 16'h0020
`define SFR_ADDR_MINFO_FIRST 16'h0064
`define SFR_ADDR_MINFO_LAST 16'h0083

// ---------------------------------------------------------------
// status word bit positions
// ---------------------------------------------------------------
`define SFR_ST_ON 0
`define SFR_ST_FAULT 1
`define SFR_ST_ANALOG 2
`define SFR_ST_BUS 3
`define SFR_ST_CURRENT 4
`define SFR_ST_VOLTAGE 5
`define SFR_ST_RESET 16'h0000

// ---------------------------------------------------------------
// command register bit positions
// ---------------------------------------------------------------
`define SFR_CMD_FAULT_CLR 1
`define SFR_CMD_ENERGY_CLR 8

// ---------------------------------------------------------------
// fault cause bit positions and widths
// ---------------------------------------------------------------
`define SFR_FAULT_W 21
`define SFR_F_MODULE 0
`define SFR_F_OUT_Z 1
`define SFR_F_COMMAND 2
`define SFR_F_CTRL_HW 3
`define SFR_F_SUPERVISORY 4
`define SFR_F_ANALOG_P 5
`define SFR_F_ANALOG_I 6
`define SFR_F_ANALOG_V 7
`define SFR_F_SENSE 8
`define SFR_F_BUS_TIMEOUT 9
`define SFR_F_SUPER_WARN 10
`define SFR_F_UNIT_SILENT 11
`define SFR_F_DUP_ID 12
`define SFR_F_OVERCOUNT 13
`define SFR_F_DUP_SERIAL 14
`define SFR_F_Z_SLOPE 15
`define SFR_F_CABLE_Z 16
`define SFR_F_UNDERCOUNT 17
`define SFR_F_PHASE 18
`define SFR_F_ANALOG_INHIBIT 19
`define SFR_F_ANALOG_OVERLOAD 20
`define SFR_FAULT_RESET 21'h000000

// ---------------------------------------------------------------
// module table and energy counter reset
// ---------------------------------------------------------------
`define SFR_MOD_COUNT 32
`define SFR_MOD_ADDR_W 12
`define SFR_ENERGY_RESET 32'h00000000

`endif

// ===== include/sfr_pkg.sv
// types and word helpers shared by the status bank modules
// assumes: sfr_map.svh on the include path
`include "sfr_map.svh"

package sfr_pkg;

   typedef logic [15:0] sfr_word_t;
   typedef logic [31:0] sfr_long_t;
   typedef logic [`SFR_FAULT_W-1:0] sfr_fault_t;
   typedef logic [`SFR_MOD_ADDR_W-1:0] sfr_mod_addr_t;

   // upper half of a 32-bit value
   function automatic sfr_word_t sfr_hi_word(input sfr_long_t v);
      return v[31:16];
   endfunction

   // lower half of a 32-bit value
   function automatic sfr_word_t sfr_lo_word(input sfr_long_t v);
      return v[15:0];
   endfunction

   // ten-fraction-bit value rescaled to fifteen fraction bits
   function automatic sfr_long_t sfr_q10_to_q15(input sfr_long_t v);
      return {v[26:0], 5'h00};
   endfunction

endpackage

// ===== include/sfr_fault_if.sv
// carrier between the bank core and the sticky fault trap
// assumes: one clock domain, driven by sfr_status_bank
`timescale 1ns/1ps

interface sfr_fault_if;
   sfr_pkg::sfr_fault_t cause;
   logic clr;
   sfr_pkg::sfr_fault_t flags;
   logic fault_flag;

   modport trap (input cause, input clr, output flags, output fault_flag);
   modport core (output cause, output clr, input flags, input fault_flag);
endinterface

// ===== verilog/sfr_fault_trap.sv
// sticky fault cause register and summary fault flag
// assumes: synchronous reset copy, clock enable from the bank core
`timescale 1ns/1ps
`include "sfr_map.svh"

module sfr_fault_trap (
   // clock and control
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ce,
   // fault carrier
   sfr_fault_if.trap fb
);

   sfr_pkg::sfr_fault_t flags_reg;
   sfr_pkg::sfr_fault_t flags_next;
   logic fault_reg;
   logic fault_next;
   logic cause_any;

   // set wins over clear for every bit
   assign cause_any = |fb.cause;
   assign flags_next = (flags_reg & ~{`SFR_FAULT_W{fb.clr}}) | fb.cause;
   assign fault_next = (fault_reg & ~fb.clr) | cause_any;
   assign fb.flags = flags_reg;
   assign fb.fault_flag = fault_reg;

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         flags_reg <= `SFR_FAULT_RESET;
         fault_reg <= 1'b0;
      end
      else if (ce)
      begin
         flags_reg <= flags_next;
         fault_reg <= fault_next;
      end
   end

   property p_fault_hold;
      @(posedge clk_sys) disable iff (!rst_n)
      ce && fault_reg && !fb.clr |=> fault_reg;
   endproperty
   a_fault_hold: assert property (p_fault_hold)
      else $error("fault flag dropped without clear");

   property p_causes_all_kept;
      @(posedge clk_sys) disable iff (!rst_n)
      ce |=> (flags_reg & $past(fb.cause)) == $past(fb.cause);
   endproperty
   a_causes_all_kept: assert property (p_causes_all_kept)
      else $error("concurrent fault cause lost");

   property p_flag_with_cause;
      @(posedge clk_sys) disable iff (!rst_n)
      ce && cause_any |=> fault_reg && (flags_reg != `SFR_FAULT_RESET);
   endproperty
   a_flag_with_cause: assert property (p_flag_with_cause)
      else $error("fault flag not set with cause bit");

endmodule

// ===== verilog/sfr_energy_meter.sv
// cumulative energy counter with clear
// assumes: tick is a one-cycle pulse per energy unit
`timescale 1ns/1ps
`include "sfr_map.svh"

module sfr_energy_meter (
   // clock and control
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ce,
   // counting
   input wire logic tick,
   input wire logic clr,
   output logic [31:0] count
);

   logic [31:0] count_reg;
   logic [31:0] count_next;

   // a tick in the clear cycle is counted from zero
   assign count_next = clr ? {31'h00000000, tick}
      : count_reg + {31'h0, tick};
   assign count = count_reg;

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         count_reg <= `SFR_ENERGY_RESET;
      else if (ce)
         count_reg <= count_next;
   end

   property p_energy_clear;
      @(posedge clk_sys) disable iff (!rst_n)
      ce && clr |=> count_reg == {31'h00000000, $past(tick)};
   endproperty
   a_energy_clear: assert property (p_energy_clear)
      else $error("energy counter not cleared");

endmodule

// ===== bench/sfr_host_model.sv
// host model: register reads and command writes toward the status bank
// assumes: bank answers one cycle after an accepted read
`timescale 1ns/1ps

module sfr_host_model (
   // clock
   input wire logic clk_sys,
   // read port
   output logic rd_en,
   output logic [15:0] rd_addr,
   input wire logic [15:0] rd_data,
   input wire logic rd_valid,
   // command port
   output logic cmd_wr,
   output logic [15:0] cmd_data
);
   initial
   begin
      rd_en = 1'b0;
      rd_addr = 16'hffff;
      cmd_wr = 1'b0;
      cmd_data = 16'hffff;
   end

   // released lines show the inverse of the last value
   task automatic read16(input logic [15:0] a, output logic [15:0] d);
      int n;
      @(posedge clk_sys);
      rd_en <= 1'b1;
      rd_addr <= a;
      @(posedge clk_sys);
      rd_en <= 1'b0;
      rd_addr <= ~a;
      d = 16'hxxxx;
      n = 0;
      #1;
      while (rd_valid !== 1'b1 && n < 4)
      begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      if (rd_valid === 1'b1)
         d = rd_data;
   endtask

   // high word at the lower address, low word next
   task automatic read32(input logic [15:0] a, output logic [31:0] d);
      logic [15:0] hi;
      logic [15:0] lo;
      read16(a, hi);
      read16(a + 16'h0001, lo);
      d = {hi, lo};
   endtask

   task automatic write_cmd(input logic [15:0] d);
      @(posedge clk_sys);
      cmd_wr <= 1'b1;
      cmd_data <= d;
      @(posedge clk_sys);
      cmd_wr <= 1'b0;
      cmd_data <= ~d;
   endtask
endmodule

// ===== bench/test_sfr_status_bank.sv
// self-checking bench for the status, fault and module-information bank
// assumes: sfr_host_model drives the read and command ports
`timescale 1ns/1ps

module test_sfr_status_bank;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic ce = 1'b1;
   logic [5:0] st = 6'h00;
   logic [20:0] flt = 21'h000000;
   logic [31:0] vmon = 32'h0;
   logic [31:0] imon = 32'h0;
   logic [31:0] pmon = 32'h0;
   logic tick = 1'b0;
   logic minfo_wr = 1'b0;
   logic [4:0] slot = 5'h00;
   logic [11:0] baddr = 12'h000;
   logic rd_en, rd_valid, cmd_wr;
   logic [15:0] rd_addr, rd_data, cmd_data;
   logic [15:0] w;
   logic [31:0] d;
   int n_errors = 0;
   int total_checks = 0;
   // status per input: on, analog, bus, current, voltage, power, all
   logic [15:0] st_exp [7] = '{16'h0001, 16'h0004, 16'h0008, 16'h0010,
                               16'h0020, 16'h0030, 16'h003d};

   always #25 clk_sys = ~clk_sys;

   sfr_status_bank sfr_status_bank_inst (
      .clk_sys(clk_sys), .resetn(resetn), .ce(ce),
      .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
      .rd_valid(rd_valid), .cmd_wr(cmd_wr), .cmd_data(cmd_data),
      .unit_on(st[0]), .analog_enabled(st[1]), .bus_enabled(st[2]),
      .current_reg(st[3]), .voltage_reg(st[4]), .power_reg(st[5]),
      .vmon_q15(vmon), .imon_q15(imon), .pmon_q10(pmon),
      .energy_tick(tick),
      .flt_module(flt[0]), .flt_out_z(flt[1]), .flt_command(flt[2]),
      .flt_ctrl_hw(flt[3]), .flt_supervisory(flt[4]),
      .flt_analog_p(flt[5]), .flt_loop_low(flt[6]),
      .flt_analog_v(flt[7]), .flt_sense(flt[8]),
      .flt_bus_timeout(flt[9]), .flt_super_warn(flt[10]),
      .flt_unit_silent(flt[11]), .flt_dup_id(flt[12]),
      .flt_overcount(flt[13]), .flt_dup_serial(flt[14]),
      .flt_z_slope(flt[15]), .flt_cable_z(flt[16]),
      .flt_undercount(flt[17]), .flt_phase(flt[18]),
      .flt_analog_inhibit(flt[19]), .flt_analog_overload(flt[20]),
      .minfo_wr(minfo_wr), .minfo_slot(slot), .minfo_bus_addr(baddr)
   );

   sfr_host_model sfr_host_model_inst (
      .clk_sys(clk_sys), .rd_en(rd_en), .rd_addr(rd_addr),
      .rd_data(rd_data), .rd_valid(rd_valid), .cmd_wr(cmd_wr),
      .cmd_data(cmd_data)
   );

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("BAD t=%0t got %h want %h", $time, seen, exp);
      end
   endtask

   task automatic final_report;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ------------------------------------------------------------
   // test sequence
   // ------------------------------------------------------------
   initial
   begin
      repeat (3) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (4) @(posedge clk_sys);
      sfr_host_model_inst.read16(16'h0000, w);
      check({16'h0, w}, 32'h0);
      sfr_host_model_inst.read32(16'h0001, d);
      check(d, 32'h0);
      for (int i = 0; i < 7; i++)
      begin
         @(posedge clk_sys);
         st <= (i < 6) ? 6'(1 << i) : 6'h3f;
         sfr_host_model_inst.read16(16'h0000, w);
         check({16'h0, w}, {16'h0, st_exp[i]});
      end
      @(posedge clk_sys);
      st <= 6'h00;
      for (int i = 0; i < 21; i++)
      begin
         @(posedge clk_sys);
         flt[i] <= 1'b1;
         @(posedge clk_sys);
         flt[i] <= 1'b0;
         sfr_host_model_inst.read32(16'h0001, d);
         check(d, 32'h1 << i);
         sfr_host_model_inst.read16(16'h0000, w);
         check({16'h0, w}, 32'h2);
         sfr_host_model_inst.write_cmd(16'h0002);
         sfr_host_model_inst.read32(16'h0001, d);
         check(d, 32'h0);
         sfr_host_model_inst.read16(16'h0000, w);
         check({16'h0, w}, 32'h0);
      end
      @(posedge clk_sys);
      flt <= 21'h100401;
      @(posedge clk_sys);
      flt <= 21'h000000;
      repeat (3) @(posedge clk_sys);
      sfr_host_model_inst.read32(16'h0001, d);
      check(d, 32'h00100401);
      // monitors: 0.5 in q15, q10 1.0 read back at q15 scale
      @(posedge clk_sys);
      vmon <= 32'h00004000;
      imon <= 32'h80017ffe;
      pmon <= 32'h00000400;
      sfr_host_model_inst.read32(16'h0003, d);
      check(d, 32'h00004000);
      sfr_host_model_inst.read32(16'h0005, d);
      check(d, 32'h80017ffe);
      sfr_host_model_inst.read32(16'h0007, d);
      check(d, 32'h00008000);
      @(posedge clk_sys);
      tick <= 1'b1;
      repeat (3) @(posedge clk_sys);
      tick <= 1'b0;
      sfr_host_model_inst.read32(16'h001f, d);
      check(d, 32'h3);
      sfr_host_model_inst.write_cmd(16'h0100);
      sfr_host_model_inst.read32(16'h001f, d);
      check(d, 32'h0);
      // clock enable low: a cause and a tick are not taken
      @(posedge clk_sys);
      ce <= 1'b0;
      flt <= 21'h000008;
      tick <= 1'b1;
      @(posedge clk_sys);
      ce <= 1'b1;
      flt <= 21'h000000;
      tick <= 1'b0;
      sfr_host_model_inst.read32(16'h0001, d);
      check(d, 32'h00100401);
      sfr_host_model_inst.read32(16'h001f, d);
      check(d, 32'h0);
      @(posedge clk_sys);
      minfo_wr <= 1'b1;
      baddr <= 12'habc;
      @(posedge clk_sys);
      slot <= 5'h1f;
      baddr <= 12'hfff;
      @(posedge clk_sys);
      minfo_wr <= 1'b0;
      sfr_host_model_inst.read16(16'h0064, w);
      check({16'h0, w}, 32'h0abc);
      sfr_host_model_inst.read16(16'h0083, w);
      check({16'h0, w}, 32'h0fff);
      sfr_host_model_inst.read16(16'h0084, w);
      check({16'h0, w}, 32'h0);
      // answer strobe stands for one cycle only
      @(posedge clk_sys);
      #1;
      check({31'h0, rd_valid}, 32'h0);
      // reset in mid-run clears faults and the module table
      @(posedge clk_sys);
      resetn <= 1'b0;
      repeat (3) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (4) @(posedge clk_sys);
      sfr_host_model_inst.read32(16'h0001, d);
      check(d, 32'h0);
      sfr_host_model_inst.read16(16'h0064, w);
      check({16'h0, w}, 32'h0);
      sfr_host_model_inst.read16(16'h0000, w);
      check({16'h0, w}, 32'h0);
      final_report();
   end

   // ------------------------------------------------------------
   // watchdog
   // ------------------------------------------------------------
   initial
   begin
      #500000;
      n_errors++;
      final_report();
   end
endmodule
